// [core/instrument_error_queue.sv]
// Purpose: error queue of the instrument, twenty entries oldest first
// Assumes: all inputs come from logic on sys_clk; rst_b is the power-up reset
// Notes: the reset command does not reach this block's flops
//
// Function
// - errors come out oldest first
// - error indicator drops once the queue is empty
// - beep goes high for one cycle after each cycle with a detected or external error, stored or not
// - arrival beyond twenty stored replaces newest entry with overflow code
// - after overflow further errors are dropped until one is read
// - reading an empty queue gives code zero and changes nothing
// - power-up and clear-status command empty the queue
// - reset command leaves the queue contents alone
// - leaving the menu after the error parameter level clears all errors
// - each remote query to a non-empty queue removes and returns one head entry
// - entry is signed code; reader adds comma and quoted message up to 80
// - header word over twelve characters queues mnemonic-too-long
// - exponent above 32000 queues numeric overflow
// - mantissa over 255 significant digits queues too-many-digits
// - trigger inside a command string queues trigger-not-allowed
// - trigger outside wait state or wrong source is ignored and queued
// - initiate during a measurement is ignored and queued
// - read query with bus trigger source queues trigger deadlock
// - string over twelve characters is rejected and queued
// - new data command with full output buffer keeps old data, queues error
// - talk addressed without data command queues query-unterminated
// - output overflow with full input buffer discards data, queues error
`default_nettype none
module instrument_error_queue
   import error_queue_pkg::*;
#(
   parameter int DEPTH_P = DEPTH
)
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   input  wire parse_ev_t                ev,
   input  wire logic                     ext_err_valid,
   input  wire logic signed [CODE_W-1:0] ext_err_code,
   input  wire logic                     clear_status,
   input  wire logic                     reset_cmd,
   input  wire logic                     menu_err_level,
   input  wire logic                     menu_exit,
   input  wire logic                     query_rd,
   input  wire logic                     panel_rd,
   output logic                          rd_valid,
   output logic signed [CODE_W-1:0]      rd_code,
   output logic                          error_ind,
   output logic                          beep,
   output parse_act_t                    act
);
   localparam int PTR_W = $clog2(DEPTH_P);
   localparam int CNT_W = $clog2(DEPTH_P + 1);

   err_word_t                det_err;
   parse_act_t               det_act;
   logic signed [CODE_W-1:0] mem [DEPTH_P];
   logic [PTR_W-1:0]         head;
   logic [PTR_W-1:0]         tail;
   logic [CNT_W-1:0]         count;
   logic                     ovf;
   logic                     menu_seen;
   logic [PTR_W-1:0]         next_head;
   logic [PTR_W-1:0]         next_tail;
   logic [CNT_W-1:0]         next_count;
   logic                     next_ovf;
   logic                     next_menu_seen;
   logic                     next_rd_valid;
   logic signed [CODE_W-1:0] next_rd_code;
   logic                     next_error_ind;
   logic                     next_beep;
   logic                     wr_en;
   logic [PTR_W-1:0]         wr_idx;
   logic signed [CODE_W-1:0] wr_data;
   logic                     push;
   logic signed [CODE_W-1:0] push_code;
   logic                     pop_req;
   logic                     do_pop;
   logic                     flush;
   logic [CNT_W-1:0]         mid_count;
   logic [PTR_W-1:0]         mid_head;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      if (p == PTR_W'(DEPTH_P - 1)) begin
         ptr_inc = '0;
      end else begin
         ptr_inc = p + PTR_W'(1);
      end
   endfunction

   function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
      if (p == '0) begin
         ptr_dec = PTR_W'(DEPTH_P - 1);
      end else begin
         ptr_dec = p - PTR_W'(1);
      end
   endfunction

   error_detect u_detect (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .ev      (ev),
      .err     (det_err),
      .act     (det_act)
   );

   // detected errors take precedence over the external source for the cycle
   always_comb begin
      push      = det_err.valid | ext_err_valid;
      push_code = det_err.valid ? det_err.code : ext_err_code;
      pop_req   = query_rd | panel_rd;
   end

   always_comb begin
      next_head      = head;
      next_tail      = tail;
      next_count     = count;
      next_ovf       = ovf;
      next_menu_seen = menu_seen;
      next_rd_valid  = 1'b0;
      next_rd_code   = CODE_NONE;
      wr_en          = 1'b0;
      wr_idx         = tail;
      wr_data        = push_code;
      do_pop         = pop_req && (count != '0);
      flush          = clear_status || (menu_exit && menu_seen);
      next_beep      = push;
      mid_head       = head;
      mid_count      = count;
      if (menu_err_level) begin
         next_menu_seen = 1'b1;
      end
      if (pop_req) begin
         next_rd_valid = 1'b1;
         if (do_pop) begin
            next_rd_code = mem[head];
            mid_head     = ptr_inc(head);
            mid_count    = count - CNT_W'(1);
            next_ovf     = 1'b0;
         end else begin
            next_rd_code = CODE_NONE;
         end
      end
      next_head  = mid_head;
      next_count = mid_count;
      // pop already applied above, so a push sees the freed slot
      if (push && !next_ovf) begin
         if (mid_count == CNT_W'(DEPTH_P)) begin
            wr_en    = 1'b1;
            wr_idx   = ptr_dec(tail);
            wr_data  = CODE_OVERFLOW;
            next_ovf = 1'b1;
         end else begin
            wr_en      = 1'b1;
            wr_idx     = tail;
            next_tail  = ptr_inc(tail);
            next_count = mid_count + CNT_W'(1);
         end
      end
      if (flush) begin
         next_head      = '0;
         next_tail      = '0;
         next_count     = '0;
         next_ovf       = 1'b0;
         next_menu_seen = 1'b0;
         wr_en          = 1'b0;
      end
      if (menu_exit) begin
         next_menu_seen = 1'b0;
      end
      next_error_ind = (next_count != '0);
   end

   // reset_cmd is deliberately not used: queue state survives it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         head      <= '0;
         tail      <= '0;
         count     <= '0;
         ovf       <= 1'b0;
         menu_seen <= 1'b0;
         rd_valid  <= 1'b0;
         rd_code   <= CODE_NONE;
         error_ind <= 1'b0;
         beep      <= 1'b0;
         act       <= '0;
      end else begin
         head      <= next_head;
         tail      <= next_tail;
         count     <= next_count;
         ovf       <= next_ovf;
         menu_seen <= next_menu_seen;
         rd_valid  <= next_rd_valid;
         rd_code   <= next_rd_code;
         error_ind <= next_error_ind;
         beep      <= next_beep;
         act       <= det_act;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   sequence s_full_push;
      push && !ovf && !pop_req && count == CNT_W'(DEPTH_P) && !flush;
   endsequence

   AST_BEEP_PER_ERROR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      push |=> beep)
      else $error("beep missing after error event");
   AST_NO_BEEP_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !push |=> !beep)
      else $error("beep without error event");
   AST_IND_EMPTY: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (count == '0) |-> !error_ind)
      else $error("indicator on with empty queue");
   AST_IND_FULL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (count != '0) |-> error_ind)
      else $error("indicator off with stored errors");
   AST_OVF_MARK: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_full_push |=> ovf && count == CNT_W'(DEPTH_P) && mem[ptr_dec(tail)] == CODE_OVERFLOW)
      else $error("overflow code not placed");
   AST_OVF_DROP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ovf && !pop_req && !flush |=> $stable(count) && $stable(tail))
      else $error("error stored during overflow");
   AST_EMPTY_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pop_req && count == '0 && !push && !flush
      |=> rd_valid && rd_code == CODE_NONE && count == '0)
      else $error("empty read misbehaved");
   AST_POP_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pop_req && count != '0 && !push && !flush |=> count == $past(count) - CNT_W'(1))
      else $error("query did not remove one entry");
   AST_HEAD_DATA: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pop_req && count != '0 |=> rd_code == $past(mem[head]))
      else $error("read returned non-head entry");
   AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clear_status |=> count == '0 && !error_ind)
      else $error("clear status left entries");
   AST_RESET_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      reset_cmd && !push && !pop_req && !flush |=> $stable(count))
      else $error("reset command changed queue");

   // pointer, slot, read, overflow, menu and beep checks, so a wrong index cannot hide behind a right count
   sequence s_push_free;
      push && !ovf && !pop_req && !flush && count != CNT_W'(DEPTH_P);
   endsequence

   sequence s_pop_taken;
      pop_req && count != '0 && !flush;
   endsequence

   sequence s_pop_push_full;
      push && pop_req && !flush && count == CNT_W'(DEPTH_P);
   endsequence

   sequence s_menu_armed_exit;
      menu_exit && menu_seen;
   endsequence

   AST_PUSH_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_push_free
      |=> count == $past(count) + CNT_W'(1))
      else $error("push did not add one entry");

   AST_PUSH_DATA: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_push_free
      |=> mem[$past(tail)] == $past(push_code))
      else $error("pushed code not at tail slot");

   AST_TAIL_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_push_free
      |=> tail == ptr_inc($past(tail)))
      else $error("tail did not advance on push");

   AST_HEAD_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_pop_taken
      |=> head == ptr_inc($past(head)))
      else $error("head did not advance on read");

   AST_RD_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pop_req
      |=> rd_valid)
      else $error("read gave no answer");

   AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pop_req
      |=> !rd_valid && rd_code == CODE_NONE)
      else $error("answer without a read");

   AST_OVF_LEAVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_pop_taken
      |=> !ovf)
      else $error("overflow kept after a read");

   AST_OVF_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ovf && !pop_req && !flush
      |=> ovf)
      else $error("overflow dropped without a read");

   AST_OVF_FULL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ovf
      |-> count == CNT_W'(DEPTH_P))
      else $error("overflow set with queue not full");

   AST_COUNT_MAX: assert property (@(posedge sys_clk) disable iff (!rst_b)
      count <= CNT_W'(DEPTH_P))
      else $error("queue count above depth");

   AST_POP_PUSH_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_pop_push_full
      |=> count == CNT_W'(DEPTH_P) && !ovf)
      else $error("full read plus push lost an entry");

   AST_POP_PUSH_DATA: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_pop_push_full
      |=> mem[ptr_dec(tail)] == $past(push_code))
      else $error("full read plus push did not store code");

   AST_MENU_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_menu_armed_exit
      |=> count == '0 && !ovf && !menu_seen)
      else $error("menu exit left stored errors");

   AST_MENU_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      menu_exit && !menu_seen && !clear_status && !push && !pop_req
      |=> $stable(count))
      else $error("plain menu exit changed queue");

   AST_MENU_ARM: assert property (@(posedge sys_clk) disable iff (!rst_b)
      menu_err_level && !menu_exit && !clear_status
      |=> menu_seen)
      else $error("error level visit not remembered");

   AST_CLEAR_PTRS: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clear_status
      |=> head == '0 && tail == '0 && !ovf)
      else $error("clear status left pointers or overflow");

   AST_EMPTY_NO_OVF: assert property (@(posedge sys_clk) disable iff (!rst_b)
      count == '0
      |-> !ovf)
      else $error("overflow set with empty queue");

   AST_BEEP_DETECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      det_err.valid
      |=> beep)
      else $error("detected error gave no beep");
endmodule
`default_nettype wire

// [core/error_queue_pkg.sv]
// Purpose: shared constants and types for the instrument error queue
// Assumes: codes are signed 16-bit, messages are indexed by code in the reader
// Notes: none
`default_nettype none
package error_queue_pkg;
   localparam int DEPTH          = 20;
   localparam int CODE_W         = 16;
   localparam int MSG_MAX        = 80;
   localparam int HDR_MAX        = 12;
   localparam int STR_MAX        = 12;
   localparam int EXP_MAX        = 32000;
   localparam int DIGIT_MAX      = 255;
   localparam int LEN_W          = 16;
   localparam logic signed [15:0] CODE_NONE        = 16'sh0000;
   localparam logic signed [15:0] CODE_GET_IN_CMD  = -16'sd105;
   localparam logic signed [15:0] CODE_MNEM_LONG   = -16'sd112;
   localparam logic signed [15:0] CODE_NUM_OVF     = -16'sd123;
   localparam logic signed [15:0] CODE_DIGITS      = -16'sd124;
   localparam logic signed [15:0] CODE_TRIG_IGN    = -16'sd211;
   localparam logic signed [15:0] CODE_INIT_IGN    = -16'sd213;
   localparam logic signed [15:0] CODE_TRIG_DEAD   = -16'sd214;
   localparam logic signed [15:0] CODE_TOO_MUCH    = -16'sd223;
   localparam logic signed [15:0] CODE_OVERFLOW    = -16'sd350;
   localparam logic signed [15:0] CODE_QRY_INTR    = -16'sd410;
   localparam logic signed [15:0] CODE_QRY_UNTERM  = -16'sd420;
   localparam logic signed [15:0] CODE_QRY_DEAD    = -16'sd430;

   typedef struct packed {
      logic              hdr_done;
      logic [LEN_W-1:0]  hdr_len;
      logic              num_done;
      logic [LEN_W-1:0]  num_exp;
      logic [LEN_W-1:0]  num_digits;
      logic              str_done;
      logic [LEN_W-1:0]  str_len;
      logic              get_mid_cmd;
      logic              trig_rx;
      logic              trig_waiting;
      logic              trig_src_ok;
      logic              init_rx;
      logic              meas_busy;
      logic              read_rx;
      logic              src_is_bus;
      logic              data_cmd_rx;
      logic              obuf_full;
      logic              talk_addr;
      logic              data_cmd_seen;
      logic              obuf_over;
      logic              ibuf_full;
   } parse_ev_t;

   typedef struct packed {
      logic              trig_accept;
      logic              init_accept;
      logic              str_accept;
      logic              obuf_keep;
      logic              obuf_discard;
   } parse_act_t;

   typedef struct packed {
      logic                     valid;
      logic signed [CODE_W-1:0] code;
   } err_word_t;
endpackage
`default_nettype wire

// [core/error_detect.sv]
// Purpose: turns parser and trigger conditions into error codes and verdicts
// Assumes: each condition input is a one-cycle pulse from same-clock logic
// Notes: at most one code per cycle; highest code, nearest zero, wins
`default_nettype none
module error_detect
   import error_queue_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      rst_b,
   input  wire parse_ev_t ev,
   output var  err_word_t err,
   output var  parse_act_t act
);
   err_word_t  next_err;
   parse_act_t next_act;

   always_comb begin
      next_err = '{valid: 1'b0, code: CODE_NONE};
      next_act = '0;
      if (ev.trig_rx && ev.trig_waiting && ev.trig_src_ok) begin
         next_act.trig_accept = 1'b1;
      end
      if (ev.init_rx && !ev.meas_busy) begin
         next_act.init_accept = 1'b1;
      end
      if (ev.str_done && ev.str_len <= LEN_W'(STR_MAX)) begin
         next_act.str_accept = 1'b1;
      end
      if (ev.obuf_over && ev.ibuf_full) begin
         next_act.obuf_discard = 1'b1;
         next_err = '{valid: 1'b1, code: CODE_QRY_DEAD};
      end
      if (ev.talk_addr && !ev.data_cmd_seen) begin
         next_err = '{valid: 1'b1, code: CODE_QRY_UNTERM};
      end
      if (ev.data_cmd_rx && ev.obuf_full) begin
         next_act.obuf_keep = 1'b1;
         next_err = '{valid: 1'b1, code: CODE_QRY_INTR};
      end
      if (ev.str_done && ev.str_len > LEN_W'(STR_MAX)) begin
         next_err = '{valid: 1'b1, code: CODE_TOO_MUCH};
      end
      if (ev.read_rx && ev.src_is_bus) begin
         next_err = '{valid: 1'b1, code: CODE_TRIG_DEAD};
      end
      if (ev.init_rx && ev.meas_busy) begin
         next_err = '{valid: 1'b1, code: CODE_INIT_IGN};
      end
      if (ev.trig_rx && !(ev.trig_waiting && ev.trig_src_ok)) begin
         next_err = '{valid: 1'b1, code: CODE_TRIG_IGN};
      end
      if (ev.num_done && ev.num_digits > LEN_W'(DIGIT_MAX)) begin
         next_err = '{valid: 1'b1, code: CODE_DIGITS};
      end
      if (ev.num_done && ev.num_exp > LEN_W'(EXP_MAX)) begin
         next_err = '{valid: 1'b1, code: CODE_NUM_OVF};
      end
      if (ev.hdr_done && ev.hdr_len > LEN_W'(HDR_MAX)) begin
         next_err = '{valid: 1'b1, code: CODE_MNEM_LONG};
      end
      if (ev.get_mid_cmd) begin
         next_err = '{valid: 1'b1, code: CODE_GET_IN_CMD};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err <= '{valid: 1'b0, code: CODE_NONE};
         act <= '0;
      end else begin
         err <= next_err;
         act <= next_act;
      end
   end
endmodule
`default_nettype wire

// [tb/error_host_model.sv]
// Purpose: remote host that sends one error query and captures the answer
// Assumes: rd_code is only meaningful in the cycle that rd_valid is high
// Notes: query_rd follows req by one edge, answer is held one cycle in got
`default_nettype none
module error_host_model
   import error_queue_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   input  wire logic                     req,
   input  wire logic                     rd_valid,
   input  wire logic signed [CODE_W-1:0] rd_code,
   output logic                          query_rd,
   output logic                          got,
   output logic signed [CODE_W-1:0]      got_code
);
   timeunit 1ns;
   timeprecision 100ps;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         query_rd <= 1'b0;
         got      <= 1'b0;
         got_code <= 16'sh0000;
      end else begin
         query_rd <= req;
         got      <= (rd_valid === 1'b1);
         got_code <= rd_code;
      end
   end
endmodule
`default_nettype wire

// [tb/instrument_error_queue_tb.sv]
// Purpose: self-checking bench for the instrument error queue
// Assumes: one read at a time; pulses last one cycle
// Notes: beeps are counted by a monitor, queries go through the host model, panel reads are driven directly
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module instrument_error_queue_tb
   import error_queue_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                      sys_clk = 1'b0;
   logic                      rst_b = 1'b0;
   parse_ev_t                 ev = '0;
   logic                      ext_err_valid = 1'b0;
   logic signed [CODE_W-1:0]  ext_err_code = 16'sh0000;
   logic                      clear_status = 1'b0;
   logic                      reset_cmd = 1'b0;
   logic                      menu_err_level = 1'b0;
   logic                      menu_exit = 1'b0;
   logic                      query_rd;
   logic                      panel_rd = 1'b0;
   logic                      rd_valid;
   logic signed [CODE_W-1:0]  rd_code;
   logic                      error_ind;
   logic                      beep;
   parse_act_t                act;
   logic                      req = 1'b0;
   logic                      got;
   logic signed [CODE_W-1:0]  got_code;
   int                        num_errors = 0;
   int                        comparisons = 0;
   int                        beeps = 0;

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   instrument_error_queue #(.DEPTH_P(DEPTH)) DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .ev(ev), .ext_err_valid(ext_err_valid),
      .ext_err_code(ext_err_code), .clear_status(clear_status), .reset_cmd(reset_cmd),
      .menu_err_level(menu_err_level), .menu_exit(menu_exit), .query_rd(query_rd),
      .panel_rd(panel_rd), .rd_valid(rd_valid), .rd_code(rd_code),
      .error_ind(error_ind), .beep(beep), .act(act));

   error_host_model host (
      .sys_clk(sys_clk), .rst_b(rst_b), .req(req), .rd_valid(rd_valid),
      .rd_code(rd_code), .query_rd(query_rd), .got(got), .got_code(got_code));

   always @(posedge sys_clk) begin
      if (beep === 1'b1) begin
         beeps++;
      end
   end

   task automatic step;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic push(input logic signed [CODE_W-1:0] c);
      step;
      ext_err_valid = 1'b1;
      ext_err_code = c;
      step;
      ext_err_valid = 1'b0;
   endtask

   task automatic rd(input logic signed [CODE_W-1:0] c);
      int n;
      step;
      req = 1'b1;
      step;
      req = 1'b0;
      n = 0;
      do begin
         step;
         n++;
      end while (got !== 1'b1 && n < 8);
      `CHK(got, 1'b1)
      `CHK(got_code, c)
   endtask

   task automatic clr;
      step;
      clear_status = 1'b1;
      step;
      clear_status = 1'b0;
   endtask

   task automatic det(input parse_ev_t e, input logic signed [CODE_W-1:0] c,
                      input parse_act_t a);
      int b0;
      b0 = beeps;
      step;
      ev = e;
      step;
      ev = '0;
      step;
      `CHK(act, a)
      step;
      `CHK(beeps - b0, (c != 16'sh0000) ? 1 : 0)
      rd(c);
   endtask

   task automatic t_fifo;
      push(-16'sd113);
      push(-16'sd102);
      push(-16'sd221);
      `CHK(error_ind, 1'b1)
      step;
      panel_rd = 1'b1;
      step;
      panel_rd = 1'b0;
      `CHK(rd_valid, 1'b1)
      `CHK(rd_code, -16'sd113)
      rd(-16'sd102);
      rd(-16'sd221);
      step;
      `CHK(error_ind, 1'b0)
      rd(16'sh0000);
      rd(16'sh0000);
   endtask

   task automatic t_overflow;
      int i;
      int b0;
      b0 = beeps;
      for (i = 1; i <= 22; i++) begin
         push(16'(-i));
      end
      step;
      `CHK(beeps - b0, 22)
      rd(-16'sd1);
      push(-16'sd99);
      step;
      ext_err_valid = 1'b1;
      ext_err_code = -16'sd98;
      panel_rd = 1'b1;
      step;
      ext_err_valid = 1'b0;
      panel_rd = 1'b0;
      `CHK(rd_code, -16'sd2)
      for (i = 3; i <= 19; i++) begin
         rd(16'(-i));
      end
      rd(CODE_OVERFLOW);
      rd(-16'sd99);
      rd(-16'sd98);
      rd(16'sh0000);
   endtask

   task automatic t_same_cycle;
      step;
      ext_err_valid = 1'b1;
      ext_err_code = -16'sd7;
      panel_rd = 1'b1;
      step;
      ext_err_valid = 1'b0;
      panel_rd = 1'b0;
      `CHK(rd_code, 16'sh0000)
      step;
      `CHK(error_ind, 1'b1)
      rd(-16'sd7);
   endtask

   task automatic t_clear;
      push(-16'sd3);
      push(-16'sd4);
      step;
      reset_cmd = 1'b1;
      step;
      reset_cmd = 1'b0;
      step;
      `CHK(error_ind, 1'b1)
      rd(-16'sd3);
      clr;
      step;
      `CHK(error_ind, 1'b0)
      rd(16'sh0000);
      push(-16'sd6);
      rst_b = 1'b0;
      step;
      rst_b = 1'b1;
      step;
      `CHK(error_ind, 1'b0)
      rd(16'sh0000);
   endtask

   task automatic t_menu;
      push(-16'sd5);
      step;
      menu_exit = 1'b1;
      step;
      menu_exit = 1'b0;
      step;
      `CHK(error_ind, 1'b1)
      menu_err_level = 1'b1;
      step;
      menu_err_level = 1'b0;
      menu_exit = 1'b1;
      step;
      menu_exit = 1'b0;
      step;
      `CHK(error_ind, 1'b0)
      rd(16'sh0000);
   endtask

   task automatic t_detect;
      det(parse_ev_t'{hdr_done:1'b1, hdr_len:16'h000d, default:'0}, CODE_MNEM_LONG, '0);
      det(parse_ev_t'{hdr_done:1'b1, hdr_len:16'h000c, default:'0}, CODE_NONE, '0);
      det(parse_ev_t'{num_done:1'b1, num_exp:16'h7d01, default:'0}, CODE_NUM_OVF, '0);
      det(parse_ev_t'{num_done:1'b1, num_exp:16'h7d00, default:'0}, CODE_NONE, '0);
      det(parse_ev_t'{num_done:1'b1, num_digits:16'h0100, default:'0}, CODE_DIGITS, '0);
      det(parse_ev_t'{get_mid_cmd:1'b1, default:'0}, CODE_GET_IN_CMD, '0);
      det(parse_ev_t'{trig_rx:1'b1, trig_src_ok:1'b1, default:'0}, CODE_TRIG_IGN, '0);
      det(parse_ev_t'{trig_rx:1'b1, trig_waiting:1'b1, default:'0}, CODE_TRIG_IGN, '0);
      det(parse_ev_t'{trig_rx:1'b1, trig_waiting:1'b1, trig_src_ok:1'b1, default:'0},
          CODE_NONE, parse_act_t'{trig_accept:1'b1, default:'0});
      det(parse_ev_t'{init_rx:1'b1, meas_busy:1'b1, default:'0}, CODE_INIT_IGN, '0);
      det(parse_ev_t'{init_rx:1'b1, default:'0},
          CODE_NONE, parse_act_t'{init_accept:1'b1, default:'0});
      det(parse_ev_t'{read_rx:1'b1, src_is_bus:1'b1, default:'0}, CODE_TRIG_DEAD, '0);
      det(parse_ev_t'{str_done:1'b1, str_len:16'h000d, default:'0}, CODE_TOO_MUCH, '0);
      det(parse_ev_t'{str_done:1'b1, str_len:16'h000c, default:'0},
          CODE_NONE, parse_act_t'{str_accept:1'b1, default:'0});
      det(parse_ev_t'{data_cmd_rx:1'b1, obuf_full:1'b1, default:'0}, CODE_QRY_INTR,
          parse_act_t'{obuf_keep:1'b1, default:'0});
      det(parse_ev_t'{talk_addr:1'b1, default:'0}, CODE_QRY_UNTERM, '0);
      det(parse_ev_t'{obuf_over:1'b1, ibuf_full:1'b1, default:'0}, CODE_QRY_DEAD,
          parse_act_t'{obuf_discard:1'b1, default:'0});
   endtask

   task automatic summarize;
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      summarize;
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      t_fifo;
      t_overflow;
      t_same_cycle;
      t_clear;
      t_menu;
      t_detect;
      summarize;
   end
endmodule
`default_nettype wire
